// *** hdl/sram_pkg.sv ***
// constants and carrier types of the dual-port two-word burst sram command and bank logic
// assumes one 200 mhz reference clock that oversamples every pin of the memory interface
package sram_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int DATA_W     = 18;
  localparam int ADDR_W     = 6;
  localparam int BANK_W     = 3;
  localparam int NPORT      = 2;
  localparam int FIFO_DEPTH = 16;

  // ****************************************************************
  // latencies, in main-clock cycles and in half steps
  // ****************************************************************
  localparam int RD_LAT_CYC = 8;
  localparam int WR_LAT_CYC = 5;
  localparam int RD_STEPS   = 2 * RD_LAT_CYC;
  localparam int WR_STEPS   = 2 * WR_LAT_CYC;
  localparam int RD_VALID   = RD_STEPS - 1;
  localparam int RD_W0      = RD_STEPS;
  localparam int RD_W1      = RD_STEPS + 1;
  localparam int WR_ARM     = WR_STEPS - 1;
  localparam int BURST_LEN  = 2;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic RST_OE_N  = 1'b1;
  localparam logic RST_LEVEL = 1'b0;

  typedef struct packed {
    logic              load_n;
    logic              rw_n;
    logic              wclk;
    logic              inv;
    logic [DATA_W-1:0] dq;
  } port_pin_s;

  typedef struct packed {
    logic                       ck;
    logic [ADDR_W-1:0]          addr;
    port_pin_s [NPORT-1:0]      port;
  } pin_s;

  typedef struct packed {
    logic [RD_W1:0]                  rd_sr;
    logic [WR_STEPS-1:0]             wr_sr;
    logic [WR_STEPS-1:0][ADDR_W-1:0] wr_addr;
    logic [1:0]                      push_cnt;
    logic [ADDR_W-1:0]               push_addr;
    logic [2:0]                      cap_cnt;
    logic [ADDR_W-1:0]               cap_cur;
    logic [ADDR_W-1:0]               cap_next;
    logic [DATA_W-1:0]               wlo;
    logic                            wclk_d;
    logic                            mem_we;
    logic [ADDR_W-1:0]               mem_wa;
    logic [2*DATA_W-1:0]             mem_wd;
    logic [DATA_W-1:0]               dq_o;
    logic                            oe_n;
    logic                            valid;
  } port_st_s;

  typedef struct packed {
    pin_s                   sync1;
    pin_s                   sync2;
    logic                   ck_d;
    logic                   a_hit;
    logic [BANK_W-1:0]      a_bank;
    logic                   rclk;
    logic                   rclk_n;
    port_st_s [NPORT-1:0]   p;
  } st_s;

endpackage

// *** hdl/dual_port_burst_sram_cmd_bank.sv ***
// command decode, data latency, read-valid strobe and bank conflict logic of a dual-port sram
// assumes every memory pin is asynchronous to ref_clk_i, which runs many times faster than the main clock
// Behaviour
// R1: port a load, read/write and address are sampled on main clock rise.
// R2: port b load, read/write and address are sampled on main clock fall.
// R3: port a with load low starts read when read/write high, else write.
// R4: port b with load low starts read when read/write high, else write.
// R5: load high ignores new commands; operations in flight still complete.
// R6: every command moves a burst of two words on its own port.
// R7: port a read data appears eight cycles after the sampling rise.
// R8: port b read data appears eight cycles after the sampling fall.
// R9: port a valid rises half cycle before first word, falls before last.
// R10: port b valid rises half cycle before first word, falls before last.
// R11: data outputs float in the cycle after the last read word.
// R12: controller drives port a write data five cycles after the rise.
// R13: controller drives port b write data five cycles after the fall.
// R14: write data and inversion flags are captured on both write clock edges.
// R15: read data and inversion flags leave double rate with the read clock.
// R16: eight banks, chosen by the three lowest address bits.
// R17: port a is never refused for a bank conflict.
// R18: port b hitting port a's bank in the same cycle is dropped.
// R19: without a port a command, port b may reach any bank.
// R20: conflict check spans one cycle only; port a is never restricted.
// R21: a dropped port b write leaves no external sign.
// R22: a dropped port b read raises no valid and keeps outputs floating.
// R23: controller centres address and control transitions around main clock edges.
// R24: a burst fills one main-clock period, one word per data clock edge.
`timescale 1ns/1ps

// ****************************************************************
// read data buffer
// ****************************************************************
module sram_rd_fifo #(
  parameter int WIDTH = sram_pkg::DATA_W,
  parameter int DEPTH = sram_pkg::FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_st_s;

  fifo_st_s         st_r;
  fifo_st_s         st_nxt;
  logic [WIDTH-1:0] buf_r [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready_o  = !((st_r.wp[AW] != st_r.rp[AW]) && (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]));
  assign out_valid_o = (st_r.wp != st_r.rp);
  assign out_data_o  = buf_r[st_r.rp[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_ready_i && out_valid_o;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // storage carries no reset, only the pointers do
  always_ff @(posedge clk_i) begin
    if (push) begin
      buf_r[st_r.wp[AW-1:0]] <= in_data_i;
    end
  end
endmodule // sram_rd_fifo

// ****************************************************************
// command, bank and data timing
// ****************************************************************
module dual_port_burst_sram_cmd_bank (
  input  wire logic                        ref_clk_i,
  input  wire logic                        arst_n_i,
  input  wire logic                        main_input_clock_pair_p_i,
  input  wire logic [sram_pkg::ADDR_W-1:0] addr_i,
  input  wire logic                        first_port_load_n_i,
  input  wire logic                        first_port_read_write_n_i,
  input  wire logic                        second_port_load_n_i,
  input  wire logic                        second_port_read_write_n_i,
  input  wire logic                        first_port_write_data_clock_pair_p_i,
  input  wire logic                        second_port_write_data_clock_pair_p_i,
  input  wire logic [sram_pkg::DATA_W-1:0] first_port_data_bus_i,
  output logic      [sram_pkg::DATA_W-1:0] first_port_data_bus_o,
  output logic                             first_port_data_bus_oe_n_o,
  input  wire logic [sram_pkg::DATA_W-1:0] second_port_data_bus_i,
  output logic      [sram_pkg::DATA_W-1:0] second_port_data_bus_o,
  output logic                             second_port_data_bus_oe_n_o,
  input  wire logic                        first_port_data_inversion_flag_i,
  output logic                             first_port_data_inversion_flag_o,
  output logic                             first_port_data_inversion_flag_oe_n_o,
  input  wire logic                        second_port_data_inversion_flag_i,
  output logic                             second_port_data_inversion_flag_o,
  output logic                             second_port_data_inversion_flag_oe_n_o,
  output logic                             first_port_read_data_clock_pair_p_o,
  output logic                             first_port_read_data_clock_pair_n_o,
  output logic                             second_port_read_data_clock_pair_p_o,
  output logic                             second_port_read_data_clock_pair_n_o,
  output logic                             first_port_read_valid_o,
  output logic                             second_port_read_valid_o
);
  localparam int NP = sram_pkg::NPORT;
  localparam int DW = sram_pkg::DATA_W;

  logic [1:0]          rst_sync_r;
  logic                rst_n;
  sram_pkg::pin_s      pins;
  sram_pkg::st_s       st_r;
  sram_pkg::st_s       st_nxt;
  logic [2*DW-1:0]     mem_r [2**sram_pkg::ADDR_W];
  logic                ck_rise;
  logic                ck_fall;
  logic                hstep;
  logic [NP-1:0]       own;
  logic [NP-1:0]       conflict;
  logic [NP-1:0]       issue_rd;
  logic [NP-1:0]       issue_wr;
  logic [NP-1:0]       fifo_in_valid;
  logic [NP-1:0]       fifo_in_ready;
  logic [NP-1:0][DW-1:0] fifo_in_data;
  logic [NP-1:0]       fifo_out_valid;
  logic [NP-1:0]       fifo_out_ready;
  logic [NP-1:0][DW-1:0] fifo_out_data;

  // ****************************************************************
  // reset release and pin gathering
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  assign pins.ck             = main_input_clock_pair_p_i;
  assign pins.addr           = addr_i;
  assign pins.port[0].load_n = first_port_load_n_i;
  assign pins.port[0].rw_n   = first_port_read_write_n_i;
  assign pins.port[0].wclk   = first_port_write_data_clock_pair_p_i;
  assign pins.port[0].inv    = first_port_data_inversion_flag_i;
  assign pins.port[0].dq     = first_port_data_bus_i;
  assign pins.port[1].load_n = second_port_load_n_i;
  assign pins.port[1].rw_n   = second_port_read_write_n_i;
  assign pins.port[1].wclk   = second_port_write_data_clock_pair_p_i;
  assign pins.port[1].inv    = second_port_data_inversion_flag_i;
  assign pins.port[1].dq     = second_port_data_bus_i;

  // ****************************************************************
  // edge detection and command decode
  // ****************************************************************
  assign ck_rise = st_r.sync2.ck && !st_r.ck_d;
  assign ck_fall = !st_r.sync2.ck && st_r.ck_d;
  assign hstep   = ck_rise || ck_fall;

  // R1, R2: edge per port
  assign own = {ck_fall, ck_rise};

  generate
    for (genvar gp = 0; gp < NP; gp++) begin : g_port
      if (gp == 0) begin : g_a
        // R17, R20: never refused
        assign conflict[gp] = 1'b0;
      end else begin : g_b
        // R16, R18, R19: same-cycle bank compare
        assign conflict[gp] = st_r.a_hit && (st_r.sync2.addr[sram_pkg::BANK_W-1:0] == st_r.a_bank);
      end
      // R3, R4, R5: load gates decode
      assign issue_rd[gp] = own[gp] && !st_r.sync2.port[gp].load_n && st_r.sync2.port[gp].rw_n && !conflict[gp];
      assign issue_wr[gp] = own[gp] && !st_r.sync2.port[gp].load_n && !st_r.sync2.port[gp].rw_n && !conflict[gp];

      // R6: two words fetched per read
      assign fifo_in_valid[gp]  = (st_r.p[gp].push_cnt != 2'h0);
      assign fifo_in_data[gp]   = (st_r.p[gp].push_cnt == 2'h2) ? mem_r[st_r.p[gp].push_addr][DW-1:0]
                                                                : mem_r[st_r.p[gp].push_addr][2*DW-1:DW];
      assign fifo_out_ready[gp] = hstep && (st_r.p[gp].rd_sr[sram_pkg::RD_VALID] || st_r.p[gp].rd_sr[sram_pkg::RD_W0]);

      // sixteen words cover eight cycles of back-to-back bursts; a longer run fills it and holds each second word until the next pop
      sram_rd_fifo #(
        .WIDTH (DW),
        .DEPTH (sram_pkg::FIFO_DEPTH)
      ) u_rd_fifo (
        .clk_i       (ref_clk_i),
        .rst_n_i     (rst_n),
        .in_valid_i  (fifo_in_valid[gp]),
        .in_ready_o  (fifo_in_ready[gp]),
        .in_data_i   (fifo_in_data[gp]),
        .out_valid_o (fifo_out_valid[gp]),
        .out_ready_i (fifo_out_ready[gp]),
        .out_data_o  (fifo_out_data[gp])
      );
    end
  endgenerate

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [2:0]    cnt;
    logic [DW-1:0] word;
    cnt    = 3'h0;
    word   = '0;
    st_nxt = st_r;
    st_nxt.sync1 = pins;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.ck_d  = st_r.sync2.ck;
    if (ck_rise) begin
      st_nxt.a_hit  = !st_r.sync2.port[0].load_n;
      st_nxt.a_bank = st_r.sync2.addr[sram_pkg::BANK_W-1:0];
    end
    if (hstep) begin
      // R15: read clock follows main clock
      st_nxt.rclk   = st_r.sync2.ck;
      st_nxt.rclk_n = !st_r.sync2.ck;
    end
    for (int p = 0; p < NP; p++) begin
      st_nxt.p[p].mem_we = 1'b0;
      if (hstep) begin
        // R7, R8: half-step latency pipe
        st_nxt.p[p].rd_sr   = {st_r.p[p].rd_sr[sram_pkg::RD_W0:0], issue_rd[p]};
        st_nxt.p[p].wr_sr   = {st_r.p[p].wr_sr[sram_pkg::WR_STEPS-2:0], issue_wr[p]};
        st_nxt.p[p].wr_addr = {st_r.p[p].wr_addr[sram_pkg::WR_STEPS-2:0], st_r.sync2.addr};
        // R9, R10, R22: valid leads data
        st_nxt.p[p].valid = st_nxt.p[p].rd_sr[sram_pkg::RD_VALID] ||
                            (st_nxt.p[p].rd_sr[sram_pkg::RD_W0] && st_nxt.p[p].rd_sr[sram_pkg::RD_VALID-1]);
        // R11, R24: drive two halves only
        st_nxt.p[p].oe_n  = !(st_nxt.p[p].rd_sr[sram_pkg::RD_W0] || st_nxt.p[p].rd_sr[sram_pkg::RD_W1]);
        if (fifo_out_ready[p]) begin
          st_nxt.p[p].dq_o = fifo_out_data[p];
        end
      end
      if (issue_rd[p]) begin
        st_nxt.p[p].push_cnt  = 2'(sram_pkg::BURST_LEN);
        st_nxt.p[p].push_addr = st_r.sync2.addr;
      end else if (fifo_in_valid[p] && fifo_in_ready[p]) begin
        st_nxt.p[p].push_cnt = st_r.p[p].push_cnt - 2'h1;
      end
      // R14: capture on each write clock edge while a burst is armed; edges with cap_cnt at zero are ignored
      st_nxt.p[p].wclk_d = st_r.sync2.port[p].wclk;
      word = st_r.sync2.port[p].dq ^ {DW{st_r.sync2.port[p].inv}};
      cnt  = st_r.p[p].cap_cnt;
      if ((st_r.sync2.port[p].wclk != st_r.p[p].wclk_d) && (cnt != 3'h0)) begin
        if (!cnt[0]) begin
          st_nxt.p[p].wlo = word;
        end else begin
          st_nxt.p[p].mem_we  = 1'b1;
          st_nxt.p[p].mem_wa  = st_r.p[p].cap_cur;
          st_nxt.p[p].mem_wd  = {word, st_r.p[p].wlo};
          st_nxt.p[p].cap_cur = st_r.p[p].cap_next;
        end
        cnt = cnt - 3'h1;
      end
      // arming half a cycle early leaves the whole data eye for the two edges that follow
      if (hstep && st_nxt.p[p].wr_sr[sram_pkg::WR_ARM]) begin
        if (cnt == 3'h0) begin
          st_nxt.p[p].cap_cur = st_nxt.p[p].wr_addr[sram_pkg::WR_ARM];
        end else begin
          st_nxt.p[p].cap_next = st_nxt.p[p].wr_addr[sram_pkg::WR_ARM];
        end
        cnt = cnt + 3'(sram_pkg::BURST_LEN);
      end
      st_nxt.p[p].cap_cnt = cnt;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      for (int p = 0; p < NP; p++) begin
        st_r.p[p].oe_n <= sram_pkg::RST_OE_N;
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  // R21: dropped writes never reach the array
  always_ff @(posedge ref_clk_i) begin
    for (int p = 0; p < NP; p++) begin
      if (st_r.p[p].mem_we) begin
        mem_r[st_r.p[p].mem_wa] <= st_r.p[p].mem_wd;
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign first_port_data_bus_o                  = st_r.p[0].dq_o;
  assign first_port_data_bus_oe_n_o             = st_r.p[0].oe_n;
  assign second_port_data_bus_o                 = st_r.p[1].dq_o;
  assign second_port_data_bus_oe_n_o            = st_r.p[1].oe_n;
  // read data leaves uninverted, so the flag is a constant low driven with the data
  assign first_port_data_inversion_flag_o       = sram_pkg::RST_LEVEL;
  assign first_port_data_inversion_flag_oe_n_o  = st_r.p[0].oe_n;
  assign second_port_data_inversion_flag_o      = sram_pkg::RST_LEVEL;
  assign second_port_data_inversion_flag_oe_n_o = st_r.p[1].oe_n;
  assign first_port_read_data_clock_pair_p_o    = st_r.rclk;
  assign first_port_read_data_clock_pair_n_o    = st_r.rclk_n;
  assign second_port_read_data_clock_pair_p_o   = st_r.rclk;
  assign second_port_read_data_clock_pair_n_o   = st_r.rclk_n;
  assign first_port_read_valid_o                = st_r.p[0].valid;
  assign second_port_read_valid_o               = st_r.p[1].valid;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n);

  a_read_start: assert property (own[0] && !st_r.sync2.port[0].load_n && st_r.sync2.port[0].rw_n // R3
    |=> st_r.p[0].rd_sr[0] && !st_r.p[0].wr_sr[0]) else $error("port a read not started");
  a_write_start: assert property (own[1] && !st_r.sync2.port[1].load_n && !st_r.sync2.port[1].rw_n // R4
    && !conflict[1] |=> st_r.p[1].wr_sr[0] && !st_r.p[1].rd_sr[0]) else $error("port b write not started");
  a_load_ignore: assert property (own[0] && st_r.sync2.port[0].load_n // R5
    |=> !st_r.p[0].rd_sr[0] && !st_r.p[0].wr_sr[0]) else $error("command taken with load high");
  a_valid_lead: assert property ($rose(st_r.p[0].valid) |-> st_r.p[0].oe_n // R9
    ##1 (st_r.p[0].oe_n)[*2]) else $error("port a valid not ahead of data");
  a_valid_fall: assert property ($fell(st_r.p[1].valid) |-> !st_r.p[1].oe_n // R10
    && st_r.p[1].rd_sr[sram_pkg::RD_W0]) else $error("port b valid fell off the last word");
  a_bus_release: assert property ($rose(st_r.p[0].oe_n) |-> $past(hstep) // R11
    && !st_r.p[0].rd_sr[sram_pkg::RD_W1]) else $error("port a bus released at wrong step");
  a_read_latency: assert property ($fell(st_r.p[0].oe_n) |-> st_r.p[0].rd_sr[sram_pkg::RD_W0] // R7
    && $past(st_r.p[0].rd_sr[sram_pkg::RD_VALID])) else $error("port a read latency wrong");
  a_bank_conflict: assert property (own[1] && st_r.a_hit && !st_r.sync2.port[1].load_n // R18
    && (st_r.sync2.addr[sram_pkg::BANK_W-1:0] == st_r.a_bank)
    |=> !st_r.p[1].rd_sr[0] && !st_r.p[1].wr_sr[0]) else $error("conflicting port b access kept");
  a_port_b_free: assert property (own[1] && !st_r.a_hit && !st_r.sync2.port[1].load_n // R19
    |=> st_r.p[1].rd_sr[0] || st_r.p[1].wr_sr[0]) else $error("port b refused without port a command");
  a_write_pair: assert property (st_r.p[0].mem_we |-> $past(st_r.p[0].cap_cnt[0]) // R14
    && (st_r.p[0].cap_cnt != 3'h1)) else $error("port a write committed off a word pair");

  c_read_a: cover property ($fell(st_r.p[0].oe_n));
  c_read_b: cover property ($fell(st_r.p[1].oe_n));
  c_write_b: cover property (st_r.p[1].mem_we);
  c_conflict: cover property (own[1] && conflict[1] && !st_r.sync2.port[1].load_n);
endmodule // dual_port_burst_sram_cmd_bank

// *** dv/sram_ctrl_model.sv ***
// controller model: owns the main clock, issues commands on both ports and sends write bursts
// assumes the bench reads last_rise after each issue to time its read checks
`timescale 1ns/1ps
module sram_ctrl_model (
  input  wire logic      ref_clk_i,
  output sram_pkg::pin_s pins_o
);
  realtime last_rise;

  initial begin
    pins_o              = '1;
    pins_o.ck           = 1'b0;
    pins_o.port[0].wclk = 1'b0;
    pins_o.port[1].wclk = 1'b0;
    last_rise           = 0.0;
  end

  // main clock runs free, write clocks stand still outside bursts
  // offset by 1 ns so no main clock edge lands on a reference edge and races the first sync flop
  initial begin
    #1;
    forever #62.5 pins_o.ck = ~pins_o.ck;
  end

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic issue(input logic [1:0] ld_n, input logic [1:0] rw_n, input logic [5:0] aa, input logic [5:0] ab);
    @(negedge pins_o.ck);
    settle(6);
    pins_o.port[1].load_n = 1'b1;
    pins_o.port[0].load_n = ld_n[0];
    pins_o.port[0].rw_n   = rw_n[0];
    pins_o.addr           = aa;
    @(posedge pins_o.ck);
    last_rise = $realtime;
    settle(6);
    pins_o.port[0].load_n = 1'b1;
    pins_o.port[1].load_n = ld_n[1];
    pins_o.port[1].rw_n   = rw_n[1];
    pins_o.addr           = ab;
  endtask

  task automatic idle;
    @(negedge pins_o.ck);
    settle(6);
    pins_o.port[1].load_n = 1'b1;
    pins_o.addr           = ~pins_o.addr;
  endtask

  task automatic wr(input int p, input logic [35:0] d, input logic inv);
    if (p == 0) repeat (5) @(posedge pins_o.ck);
    else repeat (6) @(negedge pins_o.ck);
    settle(1);
    pins_o.port[p].inv = inv;
    pins_o.port[p].dq  = inv ? ~d[17:0] : d[17:0];
    settle(6);
    pins_o.port[p].wclk = ~pins_o.port[p].wclk;
    settle(6);
    pins_o.port[p].dq = inv ? ~d[35:18] : d[35:18];
    settle(6);
    pins_o.port[p].wclk = ~pins_o.port[p].wclk;
    // released lines show the inverse of data and flag, which still decodes to the last word
    settle(5);
    pins_o.port[p].dq  = ~pins_o.port[p].dq;
    pins_o.port[p].inv = ~inv;
  endtask
endmodule // sram_ctrl_model

// *** dv/tb_top.sv ***
// testbench: writes through the controller model and judges read bursts, strobes and bank conflicts
// assumes the controller model drives every controller pin and the main clock
`timescale 1ns/1ps
module tb_top;
  localparam logic [35:0] D0 = 36'h1_2345_6789;
  localparam logic [35:0] D1 = 36'ha_bcde_f012;
  localparam logic [35:0] D2 = 36'h5_a5a5_a5a5;
  localparam logic [35:0] D3 = 36'h0_0ff0_3cc3;
  localparam logic [35:0] D4 = 36'hf_1111_2222;
  logic           ref_clk = 1'b0;
  logic           arst_n  = 1'b0;
  int             miscompares = 0;
  int             samples_checked = 0;
  int             cycles = 0;
  sram_pkg::pin_s pins;
  logic [17:0]    dq_o [2];
  logic [17:0]    dq_in [2];
  logic           oe_n [2], inv_o [2], inv_oe_n [2], inv_in [2], rck [2], rckn [2], vld [2];

  always #2.5 ref_clk = ~ref_clk;

  sram_ctrl_model u_sram_ctrl_model (.ref_clk_i(ref_clk), .pins_o(pins));

  // bus level: device wins while its enable is low
  for (genvar i = 0; i < 2; i++) begin : g_wire
    assign dq_in[i]  = oe_n[i] ? pins.port[i].dq : dq_o[i];
    assign inv_in[i] = inv_oe_n[i] ? pins.port[i].inv : inv_o[i];
  end

  dual_port_burst_sram_cmd_bank u_dual_port_burst_sram_cmd_bank (
    .ref_clk_i(ref_clk), .arst_n_i(arst_n), .main_input_clock_pair_p_i(pins.ck), .addr_i(pins.addr),
    .first_port_load_n_i(pins.port[0].load_n), .first_port_read_write_n_i(pins.port[0].rw_n),
    .second_port_load_n_i(pins.port[1].load_n), .second_port_read_write_n_i(pins.port[1].rw_n),
    .first_port_write_data_clock_pair_p_i(pins.port[0].wclk),
    .second_port_write_data_clock_pair_p_i(pins.port[1].wclk),
    .first_port_data_bus_i(dq_in[0]), .first_port_data_bus_o(dq_o[0]), .first_port_data_bus_oe_n_o(oe_n[0]),
    .second_port_data_bus_i(dq_in[1]), .second_port_data_bus_o(dq_o[1]), .second_port_data_bus_oe_n_o(oe_n[1]),
    .first_port_data_inversion_flag_i(inv_in[0]), .first_port_data_inversion_flag_o(inv_o[0]),
    .first_port_data_inversion_flag_oe_n_o(inv_oe_n[0]), .second_port_data_inversion_flag_i(inv_in[1]),
    .second_port_data_inversion_flag_o(inv_o[1]), .second_port_data_inversion_flag_oe_n_o(inv_oe_n[1]),
    .first_port_read_data_clock_pair_p_o(rck[0]), .first_port_read_data_clock_pair_n_o(rckn[0]),
    .second_port_read_data_clock_pair_p_o(rck[1]), .second_port_read_data_clock_pair_n_o(rckn[1]),
    .first_port_read_valid_o(vld[0]), .second_port_read_valid_o(vld[1]));

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // samples 40 ns after each expected pin change, past the sync lag
  task automatic rd_check(input int p, input realtime t0, input logic [35:0] exp, input logic en);
    #(t0 + 977.5 - $realtime);
    chk(vld[p], en);
    #62.5;
    chk({vld[p], oe_n[p], rck[p], rckn[p], inv_o[p]}, {1'b0, !en, p == 0, p != 0, 1'b0});
    chk(inv_oe_n[p], !en);
    if (en) chk(dq_o[p], exp[17:0]);
    #62.5;
    if (en) chk({rck[p], rckn[p], dq_o[p]}, {p != 0, p == 0, exp[35:18]});
    #62.5;
    chk({oe_n[p], inv_oe_n[p]}, 2'h3);
  endtask

  task automatic wcyc(input logic [1:0] ld_n, input logic [5:0] aa, ab, input logic [35:0] da, db);
    u_sram_ctrl_model.issue(ld_n, 2'b00, aa, ab);
    fork
      if (!ld_n[0]) u_sram_ctrl_model.wr(0, da, 1'b0);
      if (!ld_n[1]) u_sram_ctrl_model.wr(1, db, 1'b1);
      u_sram_ctrl_model.idle;
    join
  endtask

  task automatic rcyc(input logic [1:0] ld_n, input logic [5:0] aa, ab, input logic [35:0] ea, eb,
                      input logic [1:0] en);
    realtime t;
    u_sram_ctrl_model.issue(ld_n, 2'b11, aa, ab);
    t = u_sram_ctrl_model.last_rise;
    fork
      rd_check(0, t, ea, en[0]);
      rd_check(1, t + 62.5, eb, en[1]);
      u_sram_ctrl_model.idle;
    join
  endtask

  // both ports write then read crosswise; port b data arrives inverted
  task automatic s_write_read;
    wcyc(2'b00, 6'h05, 6'h0e, D0, D1);
    wcyc(2'b10, 6'h11, 6'h00, D2, 36'h0);
    rcyc(2'b00, 6'h0e, 6'h05, D1, D0, 2'b11);
  endtask

  // same-bank port b write and read are dropped; a held port a lets port b through on the same bank
  task automatic s_bank_conflict;
    wcyc(2'b00, 6'h09, 6'h11, D3, D4);
    rcyc(2'b00, 6'h05, 6'h0d, D0, 36'h0, 2'b01);
    rcyc(2'b01, 6'h01, 6'h11, 36'h0, D2, 2'b10);
    rcyc(2'b10, 6'h09, 6'h00, D3, 36'h0, 2'b01);
  endtask

  // port b then port a on the same bank in consecutive cycles
  task automatic s_back_to_back;
    realtime t1, t2;
    u_sram_ctrl_model.issue(2'b01, 2'b11, 6'h00, 6'h0e);
    t1 = u_sram_ctrl_model.last_rise;
    u_sram_ctrl_model.issue(2'b10, 2'b11, 6'h0e, 6'h3f);
    t2 = u_sram_ctrl_model.last_rise;
    fork
      rd_check(1, t1 + 62.5, D1, 1'b1);
      rd_check(0, t2, D1, 1'b1);
      u_sram_ctrl_model.idle;
    join
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      wrap_up;
    end
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    repeat (20) @(posedge ref_clk);
    s_write_read;
    s_bank_conflict;
    s_back_to_back;
    wrap_up;
  end
endmodule // tb_top
